// file: rtl/sbam_map.svh
// Command codes, field positions, reset values and timing of the control block
`ifndef SBAM_MAP_SVH
`define SBAM_MAP_SVH
`define SBAM_CMD_MFG_ACCESS   8'h00
`define SBAM_CMD_CAP_ALARM    8'h01
`define SBAM_CMD_TIME_ALARM   8'h02
`define SBAM_CMD_BATT_MODE    8'h03
`define SBAM_CMD_EXT_FIRST    8'h50
`define SBAM_CMD_FULL_KEY     8'h61
`define SBAM_MA_SEAL          16'h0020
`define SBAM_MA_EXT_LO        16'h0050
`define SBAM_MA_EXT_HI        16'h005d
`define SBAM_BM_CAPACITY_UNITS_SELECT          15
`define SBAM_BM_CHARGE_BROADCAST_INHIBIT          14
`define SBAM_BM_AM            13
`define SBAM_BM_PB            9
`define SBAM_BM_CC            8
`define SBAM_BM_CF            7
`define SBAM_BM_PBS           1
`define SBAM_BM_ICC           0
`define SBAM_BM_INIT          16'h0081
`define SBAM_CAP_ALARM_INIT   16'h012c
`define SBAM_TIME_ALARM_INIT  16'h000a
`define SBAM_ENERGY_SCALE     32'h0000_2710
`define SBAM_CLK_HZ           64'd50000000
`define SBAM_AM_HOLD_S        64'd60
`define SBAM_AM_HOLD_CYC      (`SBAM_AM_HOLD_S * `SBAM_CLK_HZ)
`endif

// file: rtl/sbam_pkg.sv
// Types shared by the alarm, mode and security control block
package sbam_pkg;
   typedef enum logic [1:0] {
      SBAM_SEALED,
      SBAM_UNSEALED,
      SBAM_FULL
   } sbam_sec_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [31:0] data;
   } sbam_cmd_t;

   typedef struct packed {
      logic        ok;
      logic [31:0] data;
   } sbam_rsp_t;

   typedef struct packed {
      logic [15:0] remaining_cap;
      logic [15:0] avg_time_to_empty;
      logic [15:0] pack_mv;
      logic        discharging;
      logic        charge_wanted;
      logic        capacity_updated;
      logic        resistance_updated;
   } sbam_gauge_t;

   typedef struct packed {
      logic capacity_alarm_bit;
      logic time_alarm_bit;
   } sbam_alarm_t;
endpackage

// file: rtl/sbam_ctrl.sv
// Security states, alarm thresholds, alarm broadcast and battery-mode word
`timescale 1ns/1ps
`include "sbam_map.svh"
module sbam_ctrl
   import sbam_pkg::*;
#(
   parameter logic [31:0] AM_HOLD_CYC  = 32'(`SBAM_AM_HOLD_CYC),
   parameter logic [31:0] UNLOCK_KEY   = 32'h0123_4567,
   parameter logic [31:0] FULL_KEY     = 32'h89ab_cdef,
   parameter logic [15:0] BOOT_CODE    = 16'h0f00
) (
   input  wire logic        core_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        smb_clk_in,
   input  wire logic        cmd_valid_in,
   input  wire sbam_cmd_t   cmd_in,
   output sbam_rsp_t        rsp_out,
   output logic             rsp_valid_out,
   output logic             link_busy_out,
   input  wire sbam_gauge_t gauge_in,
   input  wire logic [15:0] ext_data_in,
   output logic [7:0]       ext_sel_out,
   output logic [15:0]      battery_mode_out,
   output logic [15:0]      cap_thr_out,
   output logic [15:0]      time_thr_out,
   output sbam_alarm_t      alarm_out,
   output logic             alarm_send_out,
   output logic             charger_send_out,
   output logic             units_change_out,
   output logic             boot_req_out,
   output logic             sealed_flag_out,
   output sbam_sec_t        sec_state_out
);

   // Unit conversion between charge and energy using the pack voltage
   function automatic logic [15:0] rescale(input logic [15:0] v,
                                            input logic [15:0] mv,
                                            input logic        to_energy);
      logic [31:0] q;
      q = 32'h0;
      if (to_energy)
         q = (32'(v) * 32'(mv)) / `SBAM_ENERGY_SCALE;
      else if (mv != 16'h0)
         q = (32'(v) * `SBAM_ENERGY_SCALE) / 32'(mv);
      else
         q = 32'(v);
      return (q > 32'h0000_ffff) ? 16'hffff : q[15:0];
   endfunction

   // Only the listed extended read codes are mapped
   function automatic logic is_ext_code(input logic [15:0] c);
      logic hit;
      hit = 1'b0;
      if (c >= `SBAM_MA_EXT_LO && c <= `SBAM_MA_EXT_HI)
         hit = !(c[3:0] == 4'h6 || c[3:0] == 4'h9 || c[3:0] == 4'hb
                 || c[3:0] == 4'hc);
      return hit;
   endfunction

   // ---------------- Link domain ----------------
   sbam_cmd_t   lreq_reg;
   logic        lreq_tgl_reg;
   logic        lbusy_reg;
   logic        ack_s1_reg;
   logic        ack_s2_reg;
   logic        ack_s3_reg;
   logic        ack_tgl_reg;
   sbam_rsp_t   crsp_reg;

   // Request capture; bundle held stable until the core acknowledges
   always_ff @(posedge smb_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lreq_reg     <= '0;
         lreq_tgl_reg <= 1'b0;
         lbusy_reg    <= 1'b0;
      end else if (cmd_valid_in && !lbusy_reg) begin
         lreq_reg     <= cmd_in;
         lreq_tgl_reg <= !lreq_tgl_reg;
         lbusy_reg    <= 1'b1;
      end else if (ack_s3_reg != ack_s2_reg) begin
         lbusy_reg    <= 1'b0;
      end
   end

   // Acknowledge toggle synchroniser and answer registers
   always_ff @(posedge smb_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ack_s1_reg    <= 1'b0;
         ack_s2_reg    <= 1'b0;
         ack_s3_reg    <= 1'b0;
         rsp_out       <= '0;
         rsp_valid_out <= 1'b0;
      end else begin
         ack_s1_reg    <= ack_tgl_reg;
         ack_s2_reg    <= ack_s1_reg;
         ack_s3_reg    <= ack_s2_reg;
         rsp_valid_out <= (ack_s3_reg != ack_s2_reg);
         if (ack_s3_reg != ack_s2_reg)
            rsp_out <= crsp_reg;
      end
   end

   assign link_busy_out = lbusy_reg;

   // ---------------- Core domain ----------------
   logic        req_s1_reg;
   logic        req_s2_reg;
   logic        req_s3_reg;
   sbam_sec_t   sec_reg;
   logic        pend_unl_reg;
   logic        pend_full_reg;
   logic [31:0] full_key_reg;
   logic [15:0] mode_reg;
   logic [15:0] cap_thr_reg;
   logic [15:0] time_thr_reg;
   logic [31:0] am_tmr_reg;
   logic [15:0] tte_prev_reg;
   logic        time_below_reg;
   logic        alarm_pend_reg;
   logic        chg_prev_reg;
   logic        take;
   logic        ma_wr;
   logic [15:0] key_word;
   logic        allowed;
   logic        seal_go;
   logic        unl_first;
   logic        unl_go;
   logic        full_first;
   logic        full_go;
   logic        mode_wr;
   logic        units_flip;
   logic        time_below;
   logic        alarm_event;

   // Request toggle synchroniser; third stage finds the edge
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         req_s1_reg <= lreq_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   // Command decode, valid only in the cycle a request is taken
   always_comb begin
      take     = (req_s3_reg != req_s2_reg);
      ma_wr    = take && lreq_reg.write
                 && lreq_reg.code == `SBAM_CMD_MFG_ACCESS;
      key_word = lreq_reg.data[15:0];
      allowed  = !(sec_reg == SBAM_SEALED
                   && lreq_reg.code >= `SBAM_CMD_EXT_FIRST)
                 && !(lreq_reg.code == `SBAM_CMD_FULL_KEY
                      && sec_reg != SBAM_FULL);
      seal_go    = ma_wr && key_word == `SBAM_MA_SEAL
                   && sec_reg != SBAM_SEALED;
      unl_first  = ma_wr && sec_reg == SBAM_SEALED && !pend_unl_reg
                   && key_word == UNLOCK_KEY[31:16];
      unl_go     = ma_wr && pend_unl_reg && key_word == UNLOCK_KEY[15:0];
      full_first = ma_wr && sec_reg == SBAM_UNSEALED && !pend_full_reg
                   && key_word == full_key_reg[31:16];
      full_go    = ma_wr && pend_full_reg
                   && key_word == full_key_reg[15:0];
      mode_wr    = take && lreq_reg.write
                   && lreq_reg.code == `SBAM_CMD_BATT_MODE;
      units_flip = mode_wr && lreq_reg.data[`SBAM_BM_CAPACITY_UNITS_SELECT]
                   != mode_reg[`SBAM_BM_CAPACITY_UNITS_SELECT];
   end

   // Security state; only reset or the seal code returns to sealed
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sec_reg <= SBAM_SEALED;
      end else begin
         case (sec_reg)
            SBAM_SEALED: begin
               if (unl_go)
                  sec_reg <= SBAM_UNSEALED;
            end
            SBAM_UNSEALED: begin
               if (seal_go)
                  sec_reg <= SBAM_SEALED;
               else if (full_go)
                  sec_reg <= SBAM_FULL;
            end
            SBAM_FULL: begin
               if (seal_go)
                  sec_reg <= SBAM_SEALED;
            end
            default: sec_reg <= SBAM_SEALED;
         endcase
      end
   end

   // pending key pair; any other command aborts it
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_unl_reg  <= 1'b0;
         pend_full_reg <= 1'b0;
      end else if (take) begin
         pend_unl_reg  <= unl_first;
         pend_full_reg <= full_first;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         full_key_reg <= FULL_KEY;
      else if (take && allowed && lreq_reg.write
               && lreq_reg.code == `SBAM_CMD_FULL_KEY)
         full_key_reg <= lreq_reg.data;
   end

   // Status and one-cycle requests towards the gauge
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ext_sel_out      <= 8'h00;
         boot_req_out     <= 1'b0;
         units_change_out <= 1'b0;
         sealed_flag_out  <= 1'b1;
         sec_state_out    <= SBAM_SEALED;
      end else begin
         if (ma_wr && sec_reg != SBAM_SEALED && is_ext_code(key_word))
            ext_sel_out <= key_word[7:0];
         else if (ma_wr)
            ext_sel_out <= 8'h00;
         boot_req_out     <= ma_wr && key_word == BOOT_CODE
                             && sec_reg == SBAM_FULL;
         units_change_out <= units_flip;
         sealed_flag_out  <= (sec_reg == SBAM_SEALED);
         sec_state_out    <= sec_reg;
      end
   end

   // Answer to the link; extended reads refused while sealed
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         crsp_reg    <= '0;
         ack_tgl_reg <= 1'b0;
      end else if (take) begin
         ack_tgl_reg   <= !ack_tgl_reg;
         crsp_reg.ok   <= allowed;
         crsp_reg.data <= 32'h0;
         if (allowed && !lreq_reg.write) begin
            case (lreq_reg.code)
               `SBAM_CMD_MFG_ACCESS:
                  crsp_reg.data <= (ext_sel_out != 8'h00)
                                   ? {16'h0, ext_data_in} : 32'h0;
               `SBAM_CMD_CAP_ALARM:  crsp_reg.data <= {16'h0, cap_thr_reg};
               `SBAM_CMD_TIME_ALARM: crsp_reg.data <= {16'h0, time_thr_reg};
               `SBAM_CMD_BATT_MODE:  crsp_reg.data <= {16'h0, mode_reg};
               `SBAM_CMD_FULL_KEY:   crsp_reg.data <= full_key_reg;
               default:              crsp_reg.data <= 32'h0;
            endcase
         end
      end
   end

   // Thresholds; capacity threshold follows the unit select
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cap_thr_reg  <= `SBAM_CAP_ALARM_INIT;
         time_thr_reg <= `SBAM_TIME_ALARM_INIT;
      end else begin
         if (take && lreq_reg.write
             && lreq_reg.code == `SBAM_CMD_CAP_ALARM)
            cap_thr_reg <= lreq_reg.data[15:0];
         else if (units_flip)
            cap_thr_reg <= rescale(cap_thr_reg, gauge_in.pack_mv,
                                   lreq_reg.data[`SBAM_BM_CAPACITY_UNITS_SELECT]);
         if (take && lreq_reg.write
             && lreq_reg.code == `SBAM_CMD_TIME_ALARM)
            time_thr_reg <= lreq_reg.data[15:0];
      end
   end

   // Battery-mode word; fixed bits never take written values
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_reg <= `SBAM_BM_INIT;
      end else begin
         if (mode_wr) begin
            mode_reg[`SBAM_BM_CAPACITY_UNITS_SELECT] <= lreq_reg.data[`SBAM_BM_CAPACITY_UNITS_SELECT];
            mode_reg[`SBAM_BM_CHARGE_BROADCAST_INHIBIT] <= lreq_reg.data[`SBAM_BM_CHARGE_BROADCAST_INHIBIT];
            mode_reg[`SBAM_BM_AM]   <= lreq_reg.data[`SBAM_BM_AM];
         end else if (mode_reg[`SBAM_BM_AM]
                      && am_tmr_reg == AM_HOLD_CYC - 32'h1) begin
            mode_reg[`SBAM_BM_AM]   <= 1'b0;
         end
         if (gauge_in.capacity_updated || gauge_in.resistance_updated)
            mode_reg[`SBAM_BM_CF] <= 1'b0;
         mode_reg[`SBAM_BM_PB]  <= 1'b0;
         mode_reg[`SBAM_BM_CC]  <= 1'b0;
         mode_reg[`SBAM_BM_PBS] <= 1'b0;
         mode_reg[`SBAM_BM_ICC] <= 1'b1;
      end
   end

   // Inhibit timer restarts on every write that sets the bit
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in)
         am_tmr_reg <= 32'h0;
      else if (mode_wr || !mode_reg[`SBAM_BM_AM])
         am_tmr_reg <= 32'h0;
      else
         am_tmr_reg <= am_tmr_reg + 32'h1;
   end

   assign time_below = time_thr_reg != 16'h0
                       && gauge_in.avg_time_to_empty < time_thr_reg;

   // Alarm status bits
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         alarm_out      <= '0;
         tte_prev_reg   <= 16'hffff;
         time_below_reg <= 1'b0;
      end else begin
         tte_prev_reg   <= gauge_in.avg_time_to_empty;
         time_below_reg <= time_below;
         if (cap_thr_reg == 16'h0)
            alarm_out.capacity_alarm_bit <= 1'b0;
         else if (gauge_in.remaining_cap < cap_thr_reg)
            alarm_out.capacity_alarm_bit <= 1'b1;
         else if (gauge_in.discharging)
            alarm_out.capacity_alarm_bit <= 1'b0;
         if (!time_below || (!gauge_in.discharging
             && gauge_in.avg_time_to_empty > tte_prev_reg))
            alarm_out.time_alarm_bit <= 1'b0;
         else if (!time_below_reg)
            alarm_out.time_alarm_bit <= 1'b1;
      end
   end

   assign alarm_event =
      (!alarm_out.capacity_alarm_bit && gauge_in.remaining_cap < cap_thr_reg
       && cap_thr_reg != 16'h0)
      || (time_below && !time_below_reg);

   // broadcast detections; all made while inhibited go out as one
   // Events seen while inhibited wait; a new event never gets lost
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         alarm_pend_reg <= 1'b0;
         alarm_send_out <= 1'b0;
      end else begin
         alarm_pend_reg <= (alarm_pend_reg || alarm_event)
                           && mode_reg[`SBAM_BM_AM];
         alarm_send_out <= (alarm_pend_reg || alarm_event)
                           && !mode_reg[`SBAM_BM_AM];
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         chg_prev_reg     <= 1'b0;
         charger_send_out <= 1'b0;
      end else begin
         chg_prev_reg     <= gauge_in.charge_wanted;
         charger_send_out <= gauge_in.charge_wanted && !chg_prev_reg
                             && !mode_reg[`SBAM_BM_CHARGE_BROADCAST_INHIBIT];
      end
   end

   assign battery_mode_out = mode_reg;
   assign cap_thr_out      = cap_thr_reg;
   assign time_thr_out     = time_thr_reg;

   // ---------------- Checks ----------------
   sequence unl_first_s;
      unl_first;
   endsequence

   sequence unl_second_s;
      pend_unl_reg && unl_go;
   endsequence

   seal_cmd_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      seal_go |=> sec_reg == SBAM_SEALED ##1 sealed_flag_out)
      else $error("seal code did not seal");

   sealed_ext_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      take && sec_reg == SBAM_SEALED
      && lreq_reg.code >= `SBAM_CMD_EXT_FIRST |=> !crsp_reg.ok)
      else $error("extended access allowed while sealed");

   unseal_pair_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      unl_first_s |=> pend_unl_reg)
      else $error("first unlock key not remembered");

   unseal_go_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      unl_second_s |=> sec_reg == SBAM_UNSEALED ##1 !sealed_flag_out)
      else $error("key pair did not unseal");

   stay_sealed_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      sec_reg == SBAM_SEALED && !unl_go |=> sec_reg == SBAM_SEALED)
      else $error("left sealed state without keys");

   full_pair_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      sec_reg == SBAM_UNSEALED && full_go && !seal_go |=> sec_reg == SBAM_FULL)
      else $error("full-access keys ignored");

   am_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      mode_reg[`SBAM_BM_AM] && !mode_wr && am_tmr_reg == AM_HOLD_CYC - 32'h1
      |=> !mode_reg[`SBAM_BM_AM] ##1 am_tmr_reg == 32'h0)
      else $error("alarm inhibit not cleared on time");

   cap_alarm_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      cap_thr_reg != 16'h0 && gauge_in.remaining_cap < cap_thr_reg
      |=> alarm_out.capacity_alarm_bit)
      else $error("capacity alarm missing");

   no_bcast_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      charger_send_out |-> !$past(mode_reg[`SBAM_BM_CHARGE_BROADCAST_INHIBIT]))
      else $error("charger broadcast while inhibited");

endmodule // sbam_ctrl

// file: test/sbam_host_model.sv
// Host-side link model: one request at a time, waits for the answer
`timescale 1ns/1ps
module sbam_host_model
   import sbam_pkg::*;
(
   input  wire logic      smb_clk_in,
   input  wire logic      link_busy_in,
   input  wire logic      rsp_valid_in,
   input  wire sbam_rsp_t rsp_in,
   output logic           cmd_valid_out,
   output sbam_cmd_t      cmd_out
);
   // Idle until the bench asks for a transfer
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out       = '0;
   end

   // keys go out as consecutive single writes
   task automatic xfer(input logic w, input logic [7:0] c,
                       input logic [31:0] d, output sbam_rsp_t r,
                       output logic to);
      int n;
      n = 0;
      @(negedge smb_clk_in);
      cmd_out       = '{write: w, code: c, data: d};
      cmd_valid_out = 1'b1;
      while (link_busy_in !== 1'b0 && n < 20) begin
         @(negedge smb_clk_in);
         n++;
      end
      @(posedge smb_clk_in);
      @(negedge smb_clk_in);
      cmd_valid_out = 1'b0;
      cmd_out       = ~cmd_out; // Stale bits never repeat the request
      while (rsp_valid_in !== 1'b1 && n < 40) begin
         @(negedge smb_clk_in);
         n++;
      end
      r  = rsp_in;
      to = (n >= 40);
   endtask
endmodule // sbam_host_model

// file: test/sbam_ctrl_tb.sv
// Self-checking bench for the security, alarm and mode control block
`timescale 1ns/1ps
module sbam_ctrl_tb;
   import sbam_pkg::*;
   logic        core_clk_in = 0, smb_clk_in = 0, resetn_in = 0;
   logic        cmd_valid_in, rsp_valid_out, link_busy_out, alarm_send_out;
   logic        charger_send_out, units_change_out, boot_req_out;
   logic        sealed_flag_out;
   sbam_cmd_t   cmd_in;
   sbam_rsp_t   rsp_out, rsp;
   sbam_gauge_t gauge_in = '0;
   sbam_alarm_t alarm_out;
   sbam_sec_t   sec_state_out;
   logic [15:0] ext_data_in = '0, battery_mode_out, cap_thr_out, time_thr_out;
   logic [7:0]  ext_sel_out;
   logic [15:0] rnd = 16'h0030, t;
   int fail_count = 0, comparisons = 0, na = 0, nc = 0, nb = 0, nu = 0, n0;

   always #10 core_clk_in = ~core_clk_in;
   // Link clock offset so its edges never meet the core edges
   initial begin
      #3;
      forever begin
         smb_clk_in = ~smb_clk_in;
         #40;
      end
   end

   // Short hold count keeps the inhibit window affordable
   sbam_ctrl #(.AM_HOLD_CYC(32'd200)) sbam_ctrl_i (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .smb_clk_in(smb_clk_in), .cmd_valid_in(cmd_valid_in),
      .cmd_in(cmd_in), .rsp_out(rsp_out), .rsp_valid_out(rsp_valid_out),
      .link_busy_out(link_busy_out), .gauge_in(gauge_in),
      .ext_data_in(ext_data_in), .ext_sel_out(ext_sel_out),
      .battery_mode_out(battery_mode_out), .cap_thr_out(cap_thr_out),
      .time_thr_out(time_thr_out), .alarm_out(alarm_out),
      .alarm_send_out(alarm_send_out), .charger_send_out(charger_send_out),
      .units_change_out(units_change_out), .boot_req_out(boot_req_out),
      .sealed_flag_out(sealed_flag_out), .sec_state_out(sec_state_out));
   sbam_host_model sbam_host_model_i (
      .smb_clk_in(smb_clk_in), .link_busy_in(link_busy_out),
      .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out),
      .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));

   // Count one-cycle pulses of the core side, away from the launching edge
   always @(negedge core_clk_in) begin
      if (alarm_send_out === 1'b1) na++;
      if (charger_send_out === 1'b1) nc++;
      if (boot_req_out === 1'b1) nb++;
      if (units_change_out === 1'b1) nu++;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wc(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic tx(input logic w, input logic [7:0] c, input logic [31:0] d);
      logic to;
      sbam_host_model_i.xfer(w, c, d, rsp, to);
      if (to) begin
         fail_count++;
         complete_run();
      end
      wc(3);
   endtask
   task automatic key(input logic [31:0] k);
      tx(1, 8'h00, {16'h0, k[31:16]});
      tx(1, 8'h00, {16'h0, k[15:0]});
   endtask

   // Main sequence: security walk, alarms, mode word, reseal
   initial begin
      wc(3);
      resetn_in = 1;
      wc(2);
      chk(battery_mode_out, 16'h0081);
      chk(sealed_flag_out, 1);
      chk(sec_state_out, SBAM_SEALED);
      tx(0, 8'h03, 0);
      chk(rsp, {1'b1, 32'h0081});
      tx(0, 8'h50, 0);
      chk(rsp.ok, 0);
      tx(0, 8'h61, 0);
      chk(rsp.ok, 0);
      tx(1, 8'h00, 32'h0123);
      tx(0, 8'h01, 0);
      tx(1, 8'h00, 32'h4567);
      chk(sec_state_out, SBAM_SEALED);
      key(32'h0123_4567);
      chk(sec_state_out, SBAM_UNSEALED);
      chk(sealed_flag_out, 0);
      tx(1, 8'h00, 32'h0f00);
      chk(nb, 0);
      key(32'h89ab_cdef);
      chk(sec_state_out, SBAM_FULL);
      tx(0, 8'h61, 0);
      chk(rsp, {1'b1, 32'h89ab_cdef});
      tx(1, 8'h61, 32'h1357_9bdf);
      tx(0, 8'h61, 0);
      chk(rsp, {1'b1, 32'h1357_9bdf});
      tx(1, 8'h00, 32'h0f00);
      chk(nb, 1);
      // Walk the whole extended range, gaps included
      for (int c = 16'h0050; c <= 16'h005d; c++) begin
         tx(1, 8'h00, c);
         t = (c inside {16'h56, 16'h59, 16'h5b, 16'h5c}) ? 16'h0 : 16'(c);
         chk(ext_sel_out, t);
      end
      rnd = lfsr(rnd);
      ext_data_in = rnd;
      tx(0, 8'h00, 0);
      chk(rsp, {1'b1, 16'h0, rnd});
      // Capacity alarm around a random threshold
      rnd = lfsr(rnd);
      t = {4'h0, rnd[11:0]} + 16'h2;
      tx(1, 8'h01, {16'h0, t});
      chk(cap_thr_out, t);
      gauge_in.remaining_cap = t - 16'h1;
      wc(4);
      chk(alarm_out.capacity_alarm_bit, 1);
      chk(na != 0, 1);
      gauge_in.remaining_cap = t;
      wc(4);
      chk(alarm_out.capacity_alarm_bit, 1);
      gauge_in.discharging = 1;
      wc(4);
      chk(alarm_out.capacity_alarm_bit, 0);
      tx(1, 8'h01, 0);
      gauge_in.remaining_cap = 0;
      wc(4);
      chk(alarm_out.capacity_alarm_bit, 0);
      // Time alarm around a random threshold
      rnd = lfsr(rnd);
      t = {4'h0, rnd[11:0]} + 16'h2;
      tx(1, 8'h02, {16'h0, t});
      chk(time_thr_out, t);
      gauge_in.avg_time_to_empty = t - 16'h1;
      wc(4);
      chk(alarm_out.time_alarm_bit, 1);
      gauge_in.avg_time_to_empty = t;
      wc(4);
      chk(alarm_out.time_alarm_bit, 0);
      // Alarm held back while inhibited, sent once it lapses
      tx(1, 8'h03, 32'h6000);
      chk(battery_mode_out[14:13], 2'b11);
      gauge_in.charge_wanted = 1;
      n0 = na;
      tx(1, 8'h01, 32'h0100);
      wc(10);
      chk(na, n0);
      chk(nc, 0);
      chk(battery_mode_out[13], 1);
      wc(200);
      chk(battery_mode_out[13], 0);
      chk(na, n0 + 1);
      gauge_in.charge_wanted = 0;
      tx(1, 8'h03, 0);
      gauge_in.charge_wanted = 1;
      wc(5);
      chk(nc != 0, 1);
      // Units change, fixed bits and read-only low byte
      n0 = nu;
      gauge_in.pack_mv = 16'h4e20;
      tx(1, 8'h03, 32'h83ff);
      chk(nu, n0 + 1);
      chk(cap_thr_out, 16'h0200);
      chk(battery_mode_out & 16'he383, 16'h8081);
      gauge_in.capacity_updated = 1;
      wc(1);
      gauge_in.capacity_updated = 0;
      wc(3);
      chk(battery_mode_out[7], 0);
      tx(1, 8'h00, 32'h0020);
      chk(sealed_flag_out, 1);
      tx(0, 8'h61, 0);
      chk(rsp.ok, 0);
      complete_run();
   end
endmodule // sbam_ctrl_tb
